// ### hdl/fiber_sgmii_interrupt_regs.v
// How it works
// R1 - ctrl bit 9 set ignores signal-detect pin
// R2 - ten enable bits, reset all enabled
// R3 - pending bits clear when status read
// R4 - status resets zero, bits 15-10 zero
// R5 - bit 9 is far-end fault received
// R6 - bits 8-5 are FIFO full/empty events
// R7 - bits 4-0 are link and negotiation events
// R8 - irq when pending, enabled and unmasked; latch always
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`include "fiber_irq_defines.vh"

module fiber_sgmii_interrupt_regs (
    input  wire                 clk_i,          // 200 MHz clock
    input  wire                 rst_i,          // sync reset, high
    input  wire                 wb_cyc_i,       // wishbone cycle
    input  wire                 wb_stb_i,       // wishbone strobe
    input  wire                 wb_we_i,        // write enable
    input  wire [`FX_ADDR_W-1:0] wb_adr_i,      // byte address
    input  wire [3:0]           wb_sel_i,       // byte selects
    input  wire [31:0]          wb_dat_i,       // write data
    output reg  [31:0]          wb_dat_o,       // read data
    output reg                  wb_ack_o,       // acknowledge
    output reg                  wb_err_o,       // unmapped address
    input  wire                 signal_detect_i, // external sd pin
    input  wire                 far_end_fault_i, // event pulses
    input  wire                 tx_fifo_full_i,
    input  wire                 tx_fifo_empty_i,
    input  wire                 rx_fifo_full_i,
    input  wire                 rx_fifo_empty_i,
    input  wire                 link_change_i,
    input  wire                 partner_fault_i,
    input  wire                 priority_resolve_fail_i,
    input  wire                 partner_next_page_i,
    input  wire                 partner_base_page_i,
    output reg                  signal_detect_o, // effective detect
    output reg                  irq_o           // level interrupt
);

    ////////////////////////////////////////////////////////////////////
    function [11:0] word_index;
        input [`FX_ADDR_W-1:0] adr;
        begin
            word_index = adr[`FX_ADDR_W-1:2];
        end
    endfunction

    function [15:0] merge16;
        input [15:0] old;
        input [31:0] wd;
        input [3:0]  sel;
        begin
            merge16[7:0]  = sel[0] ? wd[7:0]  : old[7:0];
            merge16[15:8] = sel[1] ? wd[15:8] : old[15:8];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    reg  [15:0]           ctrl_reg;
    reg  [`FX_EVT_W-1:0]  enable_reg;
    reg  [`FX_EVT_W-1:0]  mask_reg;
    wire [`FX_EVT_W-1:0]  pending;
    wire [`FX_EVT_W-1:0]  events;
    wire [11:0]           idx;
    wire                  req;
    wire                  hit;
    wire                  sts_read;
    reg  [15:0]           rd_next;
    reg  [15:0]           merged;

    localparam [15:0] EN_RST   = `FX_EVT_EN_RESET;
    localparam [15:0] MASK_RST = `FX_IRQ_MASK_RESET;

    assign idx = word_index(wb_adr_i);
    // answer one cycle after request; ack drops the cycle after
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign hit = (idx == `FX_CTRL0_IDX) | (idx == `FX_EVT_EN_IDX) |
                 (idx == `FX_EVT_STS_IDX) | (idx == `FX_IRQ_MASK_IDX);

    // R3 read clears pending
    assign sts_read = req & ~wb_we_i & (idx == `FX_EVT_STS_IDX);

    // R5 far-end fault on bit 9
    // R6 fifo events bits 8-5
    // R7 link and page events bits 4-0
    assign events = {far_end_fault_i, tx_fifo_full_i, tx_fifo_empty_i,
                     rx_fifo_full_i, rx_fifo_empty_i, link_change_i,
                     partner_fault_i, priority_resolve_fail_i,
                     partner_next_page_i, partner_base_page_i};

    // R8 latch regardless of enable
    event_latch latch_u (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .set_i (events),
        .clr_i (sts_read),
        .q_o   (pending)
    );

    ////////////////////////////////////////////////////////////////////
    always @* begin
        case (idx)
            `FX_CTRL0_IDX:
                merged = merge16(ctrl_reg, wb_dat_i, wb_sel_i);
            `FX_EVT_EN_IDX:
                merged = merge16({6'h00, enable_reg}, wb_dat_i, wb_sel_i);
            `FX_IRQ_MASK_IDX:
                merged = merge16({6'h00, mask_reg}, wb_dat_i, wb_sel_i);
            default:
                merged = 16'h0000;
        endcase
        case (idx)
            `FX_CTRL0_IDX:    rd_next = ctrl_reg;
            `FX_EVT_EN_IDX:   rd_next = {6'h00, enable_reg};
            // R4 upper bits read zero
            `FX_EVT_STS_IDX:  rd_next = {6'h00, pending};
            `FX_IRQ_MASK_IDX: rd_next = {6'h00, mask_reg};
            default:          rd_next = 16'h0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            // R1 control resets to zero
            ctrl_reg   <= `FX_CTRL0_RESET;
            // R2 all sources enabled
            enable_reg <= EN_RST[`FX_EVT_W-1:0];
            mask_reg   <= MASK_RST[`FX_EVT_W-1:0];
            wb_ack_o   <= 1'b0;
            wb_err_o   <= 1'b0;
            wb_dat_o   <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req & hit;
            wb_err_o <= req & ~hit;
            wb_dat_o <= (req & hit & ~wb_we_i) ? {16'h0000, rd_next}
                                               : 32'h0000_0000;
            if (req & wb_we_i) begin
                case (idx)
                    `FX_CTRL0_IDX: begin
                        // only bit 9 writable; rest reserved zero
                        ctrl_reg[`FX_SD_IGNORE_BIT] <=
                            merged[`FX_SD_IGNORE_BIT];
                    end
                    `FX_EVT_EN_IDX: begin
                        // R2 write 1 enables
                        enable_reg <= merged[`FX_EVT_W-1:0];
                    end
                    `FX_IRQ_MASK_IDX: begin
                        mask_reg <= merged[`FX_EVT_W-1:0];
                    end
                    default: begin
                        ctrl_reg <= ctrl_reg;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (rst_i) begin
            signal_detect_o <= 1'b0;
            irq_o           <= 1'b0;
        end else begin
            // R1 bit set forces detect, pin ignored
            signal_detect_o <= ctrl_reg[`FX_SD_IGNORE_BIT] | signal_detect_i;
            // R8 pending and enabled and unmasked
            irq_o <= |(pending & enable_reg & mask_reg);
        end
    end

endmodule // fiber_sgmii_interrupt_regs

// ### shared/fiber_irq_defines.vh
`ifndef FIBER_IRQ_DEFINES_VH
`define FIBER_IRQ_DEFINES_VH

// offsets are word indices; the bus byte address is index times four
`define FX_CTRL0_IDX      12'hC10
`define FX_EVT_EN_IDX     12'hC18
`define FX_EVT_STS_IDX    12'hC19
`define FX_IRQ_MASK_IDX   12'hC1A

`define FX_ADDR_W         14

`define FX_CTRL0_RESET    16'h0000
`define FX_EVT_EN_RESET   16'h03FF
`define FX_EVT_STS_RESET  16'h0000
`define FX_IRQ_MASK_RESET 16'h03FF

`define FX_SD_IGNORE_BIT  9
`define FX_EVT_W          10

`define FX_EVT_FAR_FAULT  9
`define FX_EVT_TXF_FULL   8
`define FX_EVT_TXF_EMPTY  7
`define FX_EVT_RXF_FULL   6
`define FX_EVT_RXF_EMPTY  5
`define FX_EVT_LINK_CHG   4
`define FX_EVT_LP_FAULT   3
`define FX_EVT_PRI_FAIL   2
`define FX_EVT_LP_NP      1
`define FX_EVT_LP_BP      0

`endif

// ### hdl/event_latch.v
`timescale 1ns/1ps
`include "fiber_irq_defines.vh"

module event_latch (
    input  wire                 clk_i,   // system clock
    input  wire                 rst_i,   // sync reset, high
    input  wire [`FX_EVT_W-1:0] set_i,   // event pulses
    input  wire                 clr_i,   // clear all, one cycle
    output reg  [`FX_EVT_W-1:0] q_o      // sticky bits
);

    localparam [15:0] STS_RST = `FX_EVT_STS_RESET;

    // set wins over a clear in the same cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= STS_RST[`FX_EVT_W-1:0];
        end else begin
            q_o <= (clr_i ? {`FX_EVT_W{1'b0}} : q_o) | set_i;
        end
    end

endmodule // event_latch

// ### tb/fiber_irq_assertions.sv
`timescale 1ns/1ps
`include "fiber_irq_defines.vh"
module fiber_irq_assertions (
    input wire                  clk_i,           // clock
    input wire                  rst_i,           // reset
    input wire                  wb_cyc_i,        // cycle
    input wire                  wb_stb_i,        // strobe
    input wire [`FX_ADDR_W-1:0] wb_adr_i,        // address
    input wire [31:0]           wb_dat_o,        // read data
    input wire                  wb_ack_o,        // ack
    input wire                  wb_err_o,        // error
    input wire                  signal_detect_i, // sd pin
    input wire                  signal_detect_o, // sd out
    input wire                  irq_o            // interrupt
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
sequence taken;
    req;
endsequence
sequence hole;
    taken ##0 wb_adr_i == 14'h3044;
endsequence
a_bus_answer: assert property (taken |=> wb_ack_o || wb_err_o)
    else $error("no answer");
a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
a_ack_err_excl: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack with err");
a_upper_zero: assert property (wb_ack_o |-> !(|wb_dat_o[31:10]))
    else $error("upper bits set");
a_idle_dat: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data when idle");
a_hole_err: assert property (hole |=> wb_err_o && !wb_ack_o)
    else $error("unmapped not refused");
a_sd_pin: assert property (signal_detect_i |=> signal_detect_o)
    else $error("detect lost");
a_irq_reset: assert property ($fell(rst_i) |-> !irq_o)
    else $error("irq after reset");
endmodule // fiber_irq_assertions

// ### tb/fiber_sgmii_interrupt_regs_bench.sv
`timescale 1ns/1ps
module fiber_sgmii_interrupt_regs_bench;
reg         clk_i = 0, rst_i = 1, cs = 0, we = 0, sdi = 0, re;
reg  [13:0] adr = 14'h0;
reg  [3:0]  sel = 4'h3;
reg  [9:0]  ev = 10'h0;
reg  [31:0] wd = 32'h0, rd;
wire [31:0] dat;
wire        ack, err, sdo, irq;
integer     fails = 0, n_tests = 0, k;
always #2.5 clk_i = ~clk_i;
fiber_sgmii_interrupt_regs uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cs), .wb_stb_i(cs), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack),
    .wb_err_o(err), .signal_detect_i(sdi), .far_end_fault_i(ev[9]),
    .tx_fifo_full_i(ev[8]), .tx_fifo_empty_i(ev[7]),
    .rx_fifo_full_i(ev[6]), .rx_fifo_empty_i(ev[5]),
    .link_change_i(ev[4]), .partner_fault_i(ev[3]),
    .priority_resolve_fail_i(ev[2]), .partner_next_page_i(ev[1]),
    .partner_base_page_i(ev[0]), .signal_detect_o(sdo), .irq_o(irq));
////////////////////////////////////////////////////////////////
task end_of_test;
    begin
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
endtask
task chk(input [8*4:1] nm, input [31:0] s, input [31:0] e);
    begin
        n_tests = n_tests + 1;
        if (s !== e) begin
            fails = fails + 1;
            $display("[FAIL] %0s exp %h seen %h", nm, e, s);
        end
    end
endtask
// answer sampled at the edge, release after it
task acc(input w, input [13:0] a, input [31:0] d);
    integer t;
    begin
        @(posedge clk_i);
        cs <= 1;
        we <= w;
        adr <= a;
        wd <= d;
        t = 0;
        do begin
            @(posedge clk_i);
            t = t + 1;
        end while (ack !== 1'b1 && err !== 1'b1 && t < 20);
        rd = dat;
        re = err;
        cs <= 0;
        if (t >= 20) begin
            fails = fails + 1;
            end_of_test;
        end
    end
endtask
task rdx(input [8*4:1] nm, input [13:0] a, input [31:0] e);
    begin
        acc(0, a, 32'h0);
        chk(nm, rd, e);
    end
endtask
task pulse(input [9:0] e);
    begin
        @(posedge clk_i) ev <= e;
        @(posedge clk_i) ev <= 10'h0;
        repeat (2) @(posedge clk_i);
    end
endtask
////////////////////////////////////////////////////////////////
initial begin
    #20000;
    fails = fails + 1;
    end_of_test;
end
initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    rdx("ctrl", 14'h3040, 32'h0);
    rdx("en", 14'h3060, 32'h3FF);
    rdx("sts", 14'h3064, 32'h0);
    acc(1, 14'h3040, 32'hFFFFFFFF);
    rdx("ctrl", 14'h3040, 32'h200);
    chk("sd_o", sdo, 1);
    acc(1, 14'h3040, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("sd_o", sdo, 0);
    sdi <= 1;
    repeat (2) @(posedge clk_i);
    chk("sd_o", sdo, 1);
    for (k = 0; k < 10; k = k + 1) begin
        pulse(10'h1 << k);
        chk("irq", irq, 1);
        rdx("sts", 14'h3064, 32'h1 << k);
        rdx("sts", 14'h3064, 32'h0);
    end
    chk("irq", irq, 0);
    // disabled events still latch, irq waits for enable
    acc(1, 14'h3060, 32'h0);
    pulse(10'h3FF);
    chk("irq", irq, 0);
    acc(1, 14'h3060, 32'h3FF);
    repeat (2) @(posedge clk_i);
    chk("irq", irq, 1);
    rdx("sts", 14'h3064, 32'h3FF);
    // mask gates irq while status still latches
    acc(1, 14'h3068, 32'h0);
    pulse(10'h010);
    chk("irq", irq, 0);
    rdx("sts", 14'h3064, 32'h010);
    acc(1, 14'h3068, 32'h3FF);
    sel <= 4'h1;
    acc(1, 14'h3060, 32'h0);
    sel <= 4'h3;
    rdx("en", 14'h3060, 32'h300);
    acc(1, 14'h3044, 32'hFFFF);
    chk("err", re, 1);
    rdx("en", 14'h3060, 32'h300);
    end_of_test;
end
endmodule // fiber_sgmii_interrupt_regs_bench
bind fiber_sgmii_interrupt_regs fiber_irq_assertions sva (.*);
